/* File: pkg/ppd_defines.svh */
// ppd_defines.svh: register indices, field positions and reset values for
// the port C/D/E pin block; included by the top module and the bench.
`ifndef PPD_DEFINES_SVH
`define PPD_DEFINES_SVH

// register indices; byte address on the bus is four times the index
`define PPD_IDX_THIRD_PORT_DATA_REG   6'h03
`define PPD_IDX_DIRC    6'h07
`define PPD_IDX_FOURTH_PORT_DATA_REG   6'h08
`define PPD_IDX_DIRD    6'h09
`define PPD_IDX_PORTE   6'h0a
`define PPD_IDX_SYSTEM_OPTION_REG_TWO    6'h39

// option register two fields
`define PPD_SYSTEM_OPTION_REG_TWO_OD_BIT   5
`define PPD_SYSTEM_OPTION_REG_TWO_MODE_LSB 0

// reset values
`define PPD_RST_THIRD_PORT_DATA_REG   8'h00
`define PPD_RST_DIRC    8'h00
`define PPD_RST_FOURTH_PORT_DATA_REG   6'h00
`define PPD_RST_DIRD    6'h00
`define PPD_RST_OD      1'b0

// number of port D lines and their serial sharing
`define PPD_PD_LINES    6
`define PPD_SCI_RX_LINE 0
`define PPD_SCI_TX_LINE 1
`define PPD_SPI_LSB     2

`endif

/* File: pkg/ppd_pkg.sv */
// ppd_pkg: types shared by the port pin block.
// assumes ppd_defines.svh is on the include path.
`default_nettype none
package ppd_pkg;

  // operating mode caught from the straps at reset
  typedef enum logic [1:0] {
    PPD_MODE_SINGLE   = 2'b00,
    PPD_MODE_EXPANDED = 2'b01,
    PPD_MODE_BOOT     = 2'b10,
    PPD_MODE_TEST     = 2'b11
  } ppd_mode_type;

  // bus handshake state
  typedef enum logic {
    PPD_BUS_IDLE = 1'b0,
    PPD_BUS_ACK  = 1'b1
  } ppd_bus_type;

  // one Wishbone request as seen by the slave
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } ppd_wb_req_type;

  // pad drive for an 8-bit group; oe_n low means the pin is driven
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } ppd_pad_type;

endpackage : ppd_pkg
`default_nettype wire

/* File: src/ppd_sync.sv */
// ppd_sync: three-stage input synchroniser with agreement filter.
// assumes inputs come from pins, asynchronous to ref_clk_i.
`default_nettype none
module ppd_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  // asynchronous levels in, filtered levels out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  if (WIDTH < 1) begin : g_chk
    $error("ppd_sync: WIDTH must be at least 1");
  end

  // s1 feeds only s2; s2 and s3 must agree before a bit moves
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      level_o <= '0;
    end else begin
      level_o <= (s2_q & s3_q) | (level_o & (s2_q | s3_q));
    end
  end

endmodule : ppd_sync
`default_nettype wire

/* File: src/ppd_top.sv */
// ppd_top: pin logic of ports C, D and E behind a classic Wishbone slave.
// assumes pads resolve level from out/oe_n; serial peripherals sit outside.
// Notes on behaviour
// - with the open-drain select set in single-chip mode, port C never drives a pin high.
// - in open-drain mode a zero bit drives low and a one bit leaves the pin floating.
// - open-drain selection acts only in single-chip mode.
// - port D has six lines, each with a data bit and a direction bit.
// - lines 0-1 are shared with the async serial channel, lines 2-5 with SPI.
// - port D reads any time; inputs give the pin, outputs the driver value.
// - port D writes always update the latch, which drives only output lines.
// - port D direction register bits 7 and 6 always read zero.
// - a direction bit of one makes an output, zero an input.
// - the port D direction register sits at 0x0009 and resets to zero.
// - port E has eight input-only lines the block never drives.
// - port E line n also feeds converter channel n.
// - after reset every port E pin is a high-impedance input.
`default_nettype none
`include "ppd_defines.svh"
module ppd_top
  import ppd_pkg::*;
#(
  parameter int PD_LINES = `PPD_PD_LINES
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // operating mode straps, caught while reset is held
  input  wire logic [1:0]  mode_strap_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // port C pads
  input  wire logic [7:0]  third_port_data_reg_i,
  output logic      [7:0]  third_port_data_reg_o,
  output logic      [7:0]  third_port_data_reg_oe_n_o,
  // port D pads
  input  wire logic [5:0]  fourth_port_data_reg_i,
  output logic      [5:0]  fourth_port_data_reg_o,
  output logic      [5:0]  fourth_port_data_reg_oe_n_o,
  // port E pads, input only
  input  wire logic [7:0]  porte_i,
  // converter channel levels
  output logic      [7:0]  adc_chan_o,
  // async serial channel side
  input  wire logic        sci_rx_en_i,
  input  wire logic        sci_tx_en_i,
  input  wire logic        sci_txd_i,
  output logic             sci_rxd_o,
  // spi side
  input  wire logic        spi_en_i,
  input  wire logic [3:0]  spi_oe_i,
  input  wire logic [3:0]  spi_dout_i,
  output logic      [3:0]  spi_din_o
);

  if (PD_LINES != 6) begin : g_chk
    $error("ppd_top: port D logic serves exactly six lines");
  end

  function automatic logic hit(input logic [7:0] adr, input logic [5:0] idx);
    hit = (adr[7:2] == idx);
  endfunction : hit

  ppd_wb_req_type req;
  ppd_bus_type    bus_q;
  ppd_mode_type   mode_q;
  ppd_pad_type    pc_pad_d;

  logic [7:0]  pc_data_q;
  logic [7:0]  pc_dir_q;
  logic [5:0]  pd_data_q;
  logic [5:0]  pd_dir_q;
  logic        od_sel_q;
  logic        od_eff;
  logic [21:0] pin_lvl;
  logic [7:0]  pc_pin;
  logic [5:0]  pd_pin;
  logic [7:0]  pe_pin;
  logic [5:0]  pd_own;
  logic [5:0]  pd_oe_d;
  logic [5:0]  pd_out_d;
  logic        wr_en;
  logic [31:0] rd_d;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 adr: wb_adr_i, dat: wb_dat_i};

  // all pins through one synchroniser bank
  ppd_sync #(
    .WIDTH (22)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   ({porte_i, fourth_port_data_reg_i, third_port_data_reg_i}),
    .level_o   (pin_lvl)
  );

  assign pc_pin = pin_lvl[7:0];
  assign pd_pin = pin_lvl[13:8];
  assign pe_pin = pin_lvl[21:14];

  // mode straps are caught while reset is held, then frozen
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_q <= ppd_mode_type'(mode_strap_i);
    end
  end

  // bus handshake: ack one cycle after the request, dropped the next
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      bus_q <= PPD_BUS_IDLE;
    end else begin
      case (bus_q)
        PPD_BUS_IDLE: if (req.cyc && req.stb) bus_q <= PPD_BUS_ACK;
        PPD_BUS_ACK:  bus_q <= PPD_BUS_IDLE;
        default:      bus_q <= PPD_BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= (bus_q == PPD_BUS_IDLE) && req.cyc && req.stb;
    end
  end

  // writes land on the edge where the master samples ack
  assign wr_en = (bus_q == PPD_BUS_ACK) && req.cyc && req.stb && req.we && req.sel[0];

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pc_data_q <= `PPD_RST_THIRD_PORT_DATA_REG;
      pc_dir_q  <= `PPD_RST_DIRC;
    end else if (wr_en) begin
      if (hit(req.adr, `PPD_IDX_THIRD_PORT_DATA_REG)) pc_data_q <= req.dat[7:0];
      if (hit(req.adr, `PPD_IDX_DIRC))  pc_dir_q  <= req.dat[7:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pd_data_q <= `PPD_RST_FOURTH_PORT_DATA_REG;
      pd_dir_q  <= `PPD_RST_DIRD;
    end else if (wr_en) begin
      // latch updates whatever the direction or serial ownership
      if (hit(req.adr, `PPD_IDX_FOURTH_PORT_DATA_REG)) pd_data_q <= req.dat[5:0];
      if (hit(req.adr, `PPD_IDX_DIRD))  pd_dir_q  <= req.dat[5:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      od_sel_q <= `PPD_RST_OD;
    end else if (wr_en && hit(req.adr, `PPD_IDX_SYSTEM_OPTION_REG_TWO)) begin
      od_sel_q <= req.dat[`PPD_SYSTEM_OPTION_REG_TWO_OD_BIT];
    end
  end

  // the select bit is kept but only counts in single-chip mode
  assign od_eff = od_sel_q && (mode_q == PPD_MODE_SINGLE);

  // port C drive
  always_comb begin
    pc_pad_d.out  = pc_data_q;
    pc_pad_d.oe_n = ~pc_dir_q;
    if (od_eff) begin
      // no high-side drive: ones float, zeros pull low
      pc_pad_d.out  = '0;
      pc_pad_d.oe_n = ~(pc_dir_q & ~pc_data_q);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      third_port_data_reg_o      <= '0;
      third_port_data_reg_oe_n_o <= '1;
    end else begin
      third_port_data_reg_o      <= pc_pad_d.out;
      third_port_data_reg_oe_n_o <= pc_pad_d.oe_n;
    end
  end

  // port D: serial functions take their lines over the general-purpose bits
  always_comb begin
    pd_own   = '0;
    pd_oe_d  = pd_dir_q;
    pd_out_d = pd_data_q;
    if (sci_rx_en_i) begin
      pd_own[`PPD_SCI_RX_LINE]  = 1'b1;
      pd_oe_d[`PPD_SCI_RX_LINE] = 1'b0;
    end
    if (sci_tx_en_i) begin
      pd_own[`PPD_SCI_TX_LINE]   = 1'b1;
      pd_oe_d[`PPD_SCI_TX_LINE]  = 1'b1;
      pd_out_d[`PPD_SCI_TX_LINE] = sci_txd_i;
    end
    if (spi_en_i) begin
      pd_own[5:2]   = 4'hf;
      pd_oe_d[5:2]  = spi_oe_i;
      pd_out_d[5:2] = spi_dout_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fourth_port_data_reg_o      <= '0;
      fourth_port_data_reg_oe_n_o <= '1;
    end else begin
      fourth_port_data_reg_o      <= pd_out_d & pd_oe_d;
      fourth_port_data_reg_oe_n_o <= ~pd_oe_d;
    end
  end

  // serial receive paths see the filtered pin levels
  assign sci_rxd_o = pd_pin[`PPD_SCI_RX_LINE];
  assign spi_din_o = pd_pin[5:2];

  // port E has no drive path; each line also feeds its converter channel
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      adc_chan_o <= '0;
    end else begin
      adc_chan_o <= porte_i;
    end
  end

  // read mux
  always_comb begin
    rd_d = '0;
    if (hit(req.adr, `PPD_IDX_THIRD_PORT_DATA_REG)) begin
      rd_d[7:0] = (pc_dir_q & pc_data_q) | (~pc_dir_q & pc_pin);
    end else if (hit(req.adr, `PPD_IDX_DIRC)) begin
      rd_d[7:0] = pc_dir_q;
    end else if (hit(req.adr, `PPD_IDX_FOURTH_PORT_DATA_REG)) begin
      // outputs show what feeds the driver, inputs the pin
      rd_d[5:0] = (pd_oe_d & pd_out_d) | (~pd_oe_d & pd_pin);
    end else if (hit(req.adr, `PPD_IDX_DIRD)) begin
      rd_d[5:0] = pd_dir_q;
    end else if (hit(req.adr, `PPD_IDX_PORTE)) begin
      rd_d[7:0] = pe_pin;
    end else if (hit(req.adr, `PPD_IDX_SYSTEM_OPTION_REG_TWO)) begin
      rd_d[`PPD_SYSTEM_OPTION_REG_TWO_OD_BIT] = od_sel_q;
      rd_d[`PPD_SYSTEM_OPTION_REG_TWO_MODE_LSB +: 2] = mode_q;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if ((bus_q == PPD_BUS_IDLE) && req.cyc && req.stb && !req.we) begin
      wb_dat_o <= rd_d;
    end
  end

  // checks

  property p_od_no_high;
    @(posedge ref_clk_i) disable iff (rst_i)
      od_eff |=> ((third_port_data_reg_o & ~third_port_data_reg_oe_n_o) == 8'h00);
  endproperty
  a_od_no_high: assert property (p_od_no_high)
    else $error("port C drove high in open-drain mode");

  property p_od_levels;
    @(posedge ref_clk_i) disable iff (rst_i)
      od_eff |=> (third_port_data_reg_oe_n_o == ~($past(pc_dir_q) & ~$past(pc_data_q)));
  endproperty
  a_od_levels: assert property (p_od_levels)
    else $error("open-drain enable does not follow data");

  property p_od_mode_only;
    @(posedge ref_clk_i) disable iff (rst_i)
      (mode_q != PPD_MODE_SINGLE) |=>
        (third_port_data_reg_o == $past(pc_data_q)) && (third_port_data_reg_oe_n_o == ~$past(pc_dir_q));
  endproperty
  a_od_mode_only: assert property (p_od_mode_only)
    else $error("open-drain acted outside single-chip mode");

  property p_dir_read_zero;
    @(posedge ref_clk_i) disable iff (rst_i)
      (bus_q == PPD_BUS_IDLE && req.cyc && req.stb && !req.we &&
       hit(req.adr, `PPD_IDX_DIRD)) |=> wb_ack_o && (wb_dat_o[7:6] == 2'b00);
  endproperty
  a_dir_read_zero: assert property (p_dir_read_zero)
    else $error("direction register upper bits not zero");

  property p_gp_dir;
    @(posedge ref_clk_i) disable iff (rst_i)
      (!sci_rx_en_i && !sci_tx_en_i && !spi_en_i) |=>
        (fourth_port_data_reg_oe_n_o == ~$past(pd_dir_q)) &&
        (fourth_port_data_reg_o == ($past(pd_dir_q) & $past(pd_data_q)));
  endproperty
  a_gp_dir: assert property (p_gp_dir)
    else $error("port D general drive wrong");

  property p_dir_reset;
    @(posedge ref_clk_i)
      rst_i |=> (pd_dir_q == 6'h00) && (fourth_port_data_reg_oe_n_o == 6'h3f);
  endproperty
  a_dir_reset: assert property (p_dir_reset)
    else $error("port D not all inputs after reset");

  property p_latch_write;
    @(posedge ref_clk_i) disable iff (rst_i)
      (wr_en && hit(req.adr, `PPD_IDX_FOURTH_PORT_DATA_REG)) |=> (pd_data_q == $past(wb_dat_i[5:0]));
  endproperty
  a_latch_write: assert property (p_latch_write)
    else $error("port D latch missed a write");

  property p_sci_tx_own;
    @(posedge ref_clk_i) disable iff (rst_i)
      sci_tx_en_i |=> !fourth_port_data_reg_oe_n_o[1] && (fourth_port_data_reg_o[1] == $past(sci_txd_i));
  endproperty
  a_sci_tx_own: assert property (p_sci_tx_own)
    else $error("transmit line not owned by serial channel");

  property p_sci_rx_in;
    @(posedge ref_clk_i) disable iff (rst_i)
      sci_rx_en_i |=> fourth_port_data_reg_oe_n_o[0];
  endproperty
  a_sci_rx_in: assert property (p_sci_rx_in)
    else $error("receive line driven while serial receive enabled");

  property p_pe_read;
    @(posedge ref_clk_i) disable iff (rst_i)
      (bus_q == PPD_BUS_IDLE && req.cyc && req.stb && !req.we &&
       hit(req.adr, `PPD_IDX_PORTE)) |=> (wb_dat_o[7:0] == $past(pe_pin));
  endproperty
  a_pe_read: assert property (p_pe_read)
    else $error("port E read not the pin level");

endmodule : ppd_top
`default_nettype wire

/* File: tb/ppd_board.sv */
// ppd_board: board around the pins; pull-ups on port C, driven levels on D and E.
// assumes pad outputs follow the out/oe_n convention, oe_n low meaning driven.
`default_nettype none
module ppd_board (
  // pad drive from the block
  input  wire logic [7:0] pc_out_i,
  input  wire logic [7:0] pc_oe_n_i,
  input  wire logic [5:0] pd_out_i,
  input  wire logic [5:0] pd_oe_n_i,
  // levels the board puts on released lines
  input  wire logic [5:0] board_d_i,
  input  wire logic [7:0] board_e_i,
  // resolved pin levels back to the block
  output logic      [7:0] pc_pin_o,
  output logic      [5:0] pd_pin_o,
  output logic      [7:0] pe_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // released port C lines sit on pull-ups, so floating open-drain lines read high
  assign pc_pin_o = (pc_out_i & ~pc_oe_n_i) | pc_oe_n_i;
  assign pd_pin_o = (pd_out_i & ~pd_oe_n_i) | (board_d_i & pd_oe_n_i);
  // the block has no drive on port E, so the board owns those lines outright
  assign pe_pin_o = board_e_i;
endmodule : ppd_board
`default_nettype wire

/* File: tb/ppd_top_bench.sv */
// ppd_top_bench: self-checking bench for the port C/D/E pin block.
// assumes ppd_board on the far side and the design defines on the include path.
`default_nettype none
`include "ppd_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ppd_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_PC = {`PPD_IDX_THIRD_PORT_DATA_REG, 2'b00};
  localparam logic [7:0] A_CD = {`PPD_IDX_DIRC, 2'b00};
  localparam logic [7:0] A_PD = {`PPD_IDX_FOURTH_PORT_DATA_REG, 2'b00};
  localparam logic [7:0] A_DD = 8'h24;
  localparam logic [7:0] A_PE = {`PPD_IDX_PORTE, 2'b00};
  localparam logic [7:0] A_O2 = {`PPD_IDX_SYSTEM_OPTION_REG_TWO, 2'b00};
  localparam logic [7:0] OD   = 8'h01 << `PPD_SYSTEM_OPTION_REG_TWO_OD_BIT;
  logic        ref_clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [1:0]  mode_strap_i;
  logic [3:0]  wb_sel_i, spi_oe_i, spi_dout_i, spi_din_o;
  logic [7:0]  wb_adr_i, third_port_data_reg_i, third_port_data_reg_o, third_port_data_reg_oe_n_o, porte_i, adc_chan_o, board_e;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [5:0]  fourth_port_data_reg_i, fourth_port_data_reg_o, fourth_port_data_reg_oe_n_o, board_d;
  logic        sci_rx_en_i, sci_tx_en_i, sci_txd_i, sci_rxd_o, spi_en_i;
  int          error_cnt, n_tests;

  ppd_top dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .mode_strap_i(mode_strap_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .third_port_data_reg_i(third_port_data_reg_i), .third_port_data_reg_o(third_port_data_reg_o), .third_port_data_reg_oe_n_o(third_port_data_reg_oe_n_o),
    .fourth_port_data_reg_i(fourth_port_data_reg_i), .fourth_port_data_reg_o(fourth_port_data_reg_o), .fourth_port_data_reg_oe_n_o(fourth_port_data_reg_oe_n_o),
    .porte_i(porte_i), .adc_chan_o(adc_chan_o), .sci_rx_en_i(sci_rx_en_i),
    .sci_tx_en_i(sci_tx_en_i), .sci_txd_i(sci_txd_i), .sci_rxd_o(sci_rxd_o),
    .spi_en_i(spi_en_i), .spi_oe_i(spi_oe_i), .spi_dout_i(spi_dout_i),
    .spi_din_o(spi_din_o));
  ppd_board board (.pc_out_i(third_port_data_reg_o), .pc_oe_n_i(third_port_data_reg_oe_n_o), .pd_out_i(fourth_port_data_reg_o),
    .pd_oe_n_i(fourth_port_data_reg_oe_n_o), .board_d_i(board_d), .board_e_i(board_e),
    .pc_pin_o(third_port_data_reg_i), .pd_pin_o(fourth_port_data_reg_i), .pe_pin_o(porte_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  task automatic wrap_up();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // one classic cycle; held until ack is seen, released at that same edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] sel);
    int i;
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= sel;
    wb_dat_i <= {24'h0, d};
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 20) begin
      error_cnt++;
      wrap_up();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : settle

  // reset longer than the synchronisers so that stale pin levels are flushed
  task automatic do_reset(input logic [1:0] mode);
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    mode_strap_i <= mode;
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
  endtask : do_reset

  function automatic logic [5:0] exp_pd(input logic [5:0] dir, dat, pin);
    return (dir & dat) | (~dir & pin);
  endfunction : exp_pd

  initial begin
    logic [5:0] dir, dat;
    logic [7:0] cd;
    {rst_i, mode_strap_i, wb_cyc_i, wb_stb_i, wb_we_i} = 6'h20;
    {wb_sel_i, wb_adr_i, wb_dat_i} = '0;
    {sci_rx_en_i, sci_tx_en_i, sci_txd_i, spi_en_i, spi_oe_i, spi_dout_i} = '0;
    board_d = 6'h15;
    board_e = 8'h5a;
    error_cnt = 0;
    n_tests = 0;
    void'($urandom(32'h1838f894));
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    settle(1);
    `CHK(third_port_data_reg_oe_n_o, 8'hff)
    `CHK(fourth_port_data_reg_oe_n_o, 6'h3f)
    wb(1'b0, A_DD, 8'h00, 4'hf);
    `CHK(rd, 32'h0)
    wb(1'b0, 8'hfc, 8'h00, 4'hf);
    `CHK(rd, 32'h0)
    wb(1'b1, A_DD, 8'hff, 4'h1);
    wb(1'b1, A_DD, 8'h00, 4'he);
    wb(1'b0, A_DD, 8'h00, 4'hf);
    `CHK(rd, 32'h3f)
    settle(1);
    `CHK(fourth_port_data_reg_oe_n_o, 6'h00)
    for (int k = 0; k < 12; k++) begin
      dir = 6'($urandom);
      dat = 6'($urandom);
      board_d <= 6'($urandom);
      board_e <= 8'($urandom);
      wb(1'b1, A_PD, {2'b00, dat}, 4'h1);
      wb(1'b1, A_DD, {2'b00, dir}, 4'h1);
      settle(6);
      wb(1'b0, A_PD, 8'h00, 4'hf);
      `CHK(rd[5:0], exp_pd(dir, dat, board_d))
      `CHK(fourth_port_data_reg_oe_n_o, ~dir)
      `CHK(fourth_port_data_reg_o & dir, dat & dir)
      wb(1'b0, A_PE, 8'h00, 4'hf);
      `CHK(rd[7:0], board_e)
      `CHK(adc_chan_o, board_e)
    end
    cd = 8'($urandom);
    wb(1'b1, A_CD, 8'hff, 4'h1);
    wb(1'b1, A_PC, cd, 4'h1);
    wb(1'b1, A_O2, OD, 4'h1);
    settle(2);
    `CHK(third_port_data_reg_oe_n_o, cd)
    `CHK(third_port_data_reg_o & ~third_port_data_reg_oe_n_o, 8'h00)
    do_reset(2'b01);
    settle(1);
    `CHK(third_port_data_reg_oe_n_o, 8'hff)
    wb(1'b1, A_CD, 8'hff, 4'h1);
    wb(1'b1, A_PC, cd, 4'h1);
    wb(1'b1, A_O2, OD, 4'h1);
    settle(2);
    `CHK(third_port_data_reg_oe_n_o, 8'h00)
    `CHK(third_port_data_reg_o, cd)
    // direction set to all outputs so the serial functions must override it
    wb(1'b1, A_DD, 8'h3f, 4'h1);
    board_d <= 6'($urandom);
    spi_oe_i <= 4'($urandom);
    spi_dout_i <= 4'($urandom);
    sci_txd_i <= 1'($urandom);
    {sci_rx_en_i, sci_tx_en_i, spi_en_i} <= 3'h7;
    settle(6);
    `CHK(fourth_port_data_reg_oe_n_o, {~spi_oe_i, 2'b01})
    `CHK(fourth_port_data_reg_o[1], sci_txd_i)
    `CHK(fourth_port_data_reg_o[5:2] & spi_oe_i, spi_dout_i & spi_oe_i)
    `CHK(sci_rxd_o, board_d[0])
    `CHK(spi_din_o, (spi_oe_i & spi_dout_i) | (~spi_oe_i & board_d[5:2]))
    wrap_up();
  end

  initial begin
    #100us;
    error_cnt++;
    wrap_up();
  end
endmodule : ppd_top_bench
`default_nettype wire
